// >>> dv/ahrd_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahrd_conv_model (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic start_i, // Conversion start pulse
  input wire logic [7:0] delay_i, // Cycles until done
  input wire logic [15:0] value_i, // Value to deliver
  output logic done_o, // One-cycle done pulse
  output logic [15:0] result_o // Valid only with done
);
  logic [7:0] cnt_ff;
  logic busy_ff;
  logic [15:0] val_ff;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      result_o <= 16'h0000;
    end else if (busy_ff && cnt_ff == 8'h00) begin
      busy_ff <= 1'b0;
      done_o <= 1'b1;
      result_o <= val_ff;
    end else begin
      // Toggle outside done so stale data can never pass for a result
      result_o <= ~result_o;
      cnt_ff <= cnt_ff - 8'h01;
      if (start_i && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay_i;
        val_ff <= value_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/test_adc_host_register_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_host_register_decode;
  import ahrd_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic trig = 1'b0;
  logic [BASE_W-1:0] base = 6'h22;
  logic [BASE_W-1:0] miss = '0;
  logic [15:0] din = 16'h0000;
  logic [15:0] value = 16'h0000;
  logic [15:0] lfsr = 16'h4830;
  logic [7:0] trdata = 8'h00;
  logic [7:0] delay = 8'h02;
  logic [15:0] corner [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  logic [7:0] cv [3] = '{8'h17, 8'h2F, 8'hF3};
  wire logic [7:0] data_o;
  wire logic [7:0] twdata;
  wire logic oe, start, done, irq, twr, trd;
  wire logic [15:0] result, dout;
  wire logic [1:0] gain, tsel;
  wire logic [2:0] mode;
  wire logic [DAC_W-1:0] dac1, dac2;
  wire ahrd_mux_t mux;
  int errors = 0;
  int comparisons = 0;
  int starts = 0;
  int treads = 0;
  int twrites = 0;

  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (start === 1'b1) starts++;
    if (trd === 1'b1) treads++;
    if (twr === 1'b1) twrites++;
  end

  ahrd_top u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .io_addr_i(addr),
    .io_data_i(wdata), .io_rd_n_i(rd_n), .io_wr_n_i(wr_n), .base_sel_i(base),
    .io_data_o(data_o), .io_data_oe_o(oe), .conv_done_i(done), .conv_result_i(result),
    .conv_start_o(start), .mux_o(mux), .gain_code_o(gain), .acq_mode_o(mode),
    .irq_flag_o(irq), .dac_one_o(dac1), .dac_two_o(dac2), .dig_in_i(din),
    .dig_out_o(dout), .timer_rdata_i(trdata), .timer_sel_o(tsel),
    .timer_wdata_o(twdata), .timer_wr_o(twr), .timer_rd_o(trd));
  ahrd_conv_model u_conv (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start | trig),
    .delay_i(delay), .value_i(value), .done_o(done), .result_o(result));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic ahrd_mux_t exp_mux(input logic [7:0] d);
    return '{d[4], d[5], d[4] & d[5], d[3:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    addr = {base ^ miss, off};
    wdata = d;
    wr_n = 1'b0;
    tick(4);
    wr_n = 1'b1;
    tick(6);
  endtask
  task automatic rd(input logic [3:0] off, output logic [7:0] d);
    addr = {base ^ miss, off};
    rd_n = 1'b0;
    tick(6);
    d = data_o;
    chk("bus drive", 16'(miss == '0), 16'(oe));
    rd_n = 1'b1;
    tick(6);
    chk("bus release", 16'h0000, 16'(oe));
  endtask
  task automatic convert(input logic [15:0] v);
    logic [7:0] lo, hi, st;
    int n;
    int s0;
    value = v;
    delay = 8'(rnd() % 16'd20);
    s0 = starts;
    wr(OFF_KICK, 8'(rnd()));
    chk("start count", 16'(s0 + 1), 16'(starts));
    n = 0;
    st = 8'h20;
    while (st[5] !== 1'b0 && n < 20) begin
      rd(OFF_STATUS, st);
      n++;
    end
    chk("pending clear", 16'h0000, 16'(st[5]));
    rd(OFF_RES_LO, lo);
    rd(OFF_STATUS, st);
    chk("pending set", 16'h0001, 16'(st[5]));
    rd(OFF_RES_HI, hi);
    chk("result", v, {hi, lo});
  endtask
  task automatic finish_test();
    $display("Comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(5000 * 100);
    errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    finish_test();
  end

  initial begin
    logic [7:0] d, h;
    logic [15:0] r;
    int s0;
    tick(5);
    rst_n_i = 1'b1;
    tick(1);
    chk("mode reset", 16'(RST_MODE), 16'(mode));
    chk("mux reset", 16'h0000, 16'(mux));
    rd(OFF_STATUS, d);
    chk("pending reset", 16'h0001, 16'(d[5]));
    foreach (corner[i]) convert(corner[i]);
    repeat (3) convert(rnd());
    for (int i = 0; i < 12; i++) begin
      d = (i < 3) ? cv[i] : 8'(rnd());
      wr(OFF_CHAN, d);
      chk("mux", 16'(exp_mux(d)), 16'(mux));
    end
    for (int i = 0; i < 4; i++) begin
      d = 8'(rnd());
      d[1:0] = 2'(i);
      wr(OFF_GAIN, d);
      chk("gain", 16'(i), 16'(gain));
    end
    miss = 6'h01;
    wr(OFF_GAIN, 8'h00);
    chk("gain outside", 16'h0003, 16'(gain));
    rd(OFF_STATUS, d);
    miss = '0;
    r = rnd();
    wr(OFF_RES_LO, r[7:0]);
    chk("dac one held", 16'h0000, 16'(dac1));
    wr(OFF_RES_HI, r[15:8]);
    chk("dac one", 16'(r[11:0]), 16'(dac1));
    rd(OFF_RES_LO, d);
    chk("result kept", 16'(value[7:0]), 16'(d));
    wr(OFF_DIN_LO, r[15:8]);
    wr(OFF_DIN_HI, r[7:0]);
    chk("dac two", 16'({r[3:0], r[15:8]}), 16'(dac2));
    wr(OFF_DOUT_LO, r[7:0]);
    wr(OFF_DOUT_HI, r[15:8]);
    chk("dig out", r, dout);
    din = rnd();
    trdata = 8'(rnd());
    tick(3);
    rd(OFF_DIN_LO, d);
    rd(OFF_DIN_HI, h);
    chk("dig in", din, {h, d});
    rd(OFF_CNT1, d);
    chk("timer read", 16'(trdata), 16'(d));
    chk("timer read sel", 16'h0001, 16'(tsel));
    chk("timer read pulse", 16'h0001, 16'(treads));
    wr(OFF_TCTL, 8'hA5);
    chk("timer write", 16'h03A5, {6'h00, tsel, twdata});
    chk("timer write pulse", 16'h0001, 16'(twrites));
    wr(OFF_SPARE, 8'hFF);
    chk("spare write", 16'(r), dout);
    rd(OFF_GAIN, d);
    chk("unused read", 16'(UNUSED_READ), 16'(d));
    rd(OFF_STATUS, d);
    chk("no side effect", 16'h0001, 16'(d[5]));
    wr(OFF_MODE, 8'h06);
    chk("mode", 16'(MODE_IRQ), 16'(mode));
    s0 = starts;
    wr(OFF_KICK, 8'h00);
    chk("kick ignored", 16'(s0), 16'(starts));
    trig = 1'b1;
    tick(1);
    trig = 1'b0;
    tick(25);
    chk("irq raised", 16'h0001, 16'(irq));
    wr(OFF_STATUS, 8'(rnd()));
    chk("irq cleared", 16'h0000, 16'(irq));
    finish_test();
  end
endmodule
`default_nettype wire

// >>> hdl/ahrd_pkg.sv
package ahrd_pkg;

  localparam int ADDR_W = 10;
  localparam int OFF_W = 4;
  localparam int BASE_W = ADDR_W - OFF_W;

  // Port offsets inside the sixteen-address block
  localparam logic [3:0] OFF_CNT0 = 4'h0;
  localparam logic [3:0] OFF_CNT1 = 4'h1;
  localparam logic [3:0] OFF_CNT2 = 4'h2;
  localparam logic [3:0] OFF_TCTL = 4'h3;
  localparam logic [3:0] OFF_RES_LO = 4'h4;
  localparam logic [3:0] OFF_RES_HI = 4'h5;
  localparam logic [3:0] OFF_DIN_LO = 4'h6;
  localparam logic [3:0] OFF_DIN_HI = 4'h7;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_GAIN = 4'h9;
  localparam logic [3:0] OFF_CHAN = 4'hA;
  localparam logic [3:0] OFF_MODE = 4'hB;
  localparam logic [3:0] OFF_KICK = 4'hC;
  localparam logic [3:0] OFF_DOUT_LO = 4'hD;
  localparam logic [3:0] OFF_DOUT_HI = 4'hE;
  localparam logic [3:0] OFF_SPARE = 4'hF;

  // Field positions
  localparam int STAT_PEND_BIT = 5;
  localparam int CHAN_IDX_LSB = 0;
  localparam int BANK_LO_BIT = 4;
  localparam int BANK_HI_BIT = 5;
  localparam int DAC_W = 12;

  // Acquisition modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SOFT = 3'h1;
  localparam logic [2:0] MODE_DMA = 3'h2;
  localparam logic [2:0] MODE_IRQ = 3'h6;

  // Values after reset, and the byte that unused reads return
  localparam logic [2:0] RST_MODE = MODE_SOFT;
  localparam logic RST_PENDING = 1'b1;
  localparam logic [1:0] RST_GAIN = 2'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] UNUSED_READ = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic rd_n;
    logic wr_n;
  } ahrd_host_t;

  typedef struct packed {
    logic low_bank_en;
    logic high_bank_en;
    logic differential;
    logic [3:0] channel_index;
  } ahrd_mux_t;

endpackage

// >>> hdl/ahrd_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Decode sixteen consecutive I/O addresses from the base; ignore everything else.
// - Result low byte reads at offset 4, high byte at offset 5.
// - Result ports are read-only; writes there load analog output one instead.
// - Result bit 15 is high byte bit 7; bit 0 is low byte bit 0.
// - Results are two's complement: 7FFF, 0000, FFFF, 8000 passed unchanged.
// - Status at offset 8 shows the pending flag in bit 5, 1 means not ready.
// - Pending flag drops when a conversion finishes, unless the low result byte is read in the same cycle.
// - Reading the low result byte sets the pending flag.
// - Channel register at offset 10: index bits 3-0, bank bits 5-4, rest ignored.
// - Each channel write switches the multiplexer at once and holds it.
// - Only bank bit 4 set: first multiplexer, inputs 0 to 7.
// - Only bank bit 5 set: second multiplexer, inputs 8 to 15.
// - Both bank bits set: differential pairs 0 to 7.
// - Gain register at offset 9, bits 1-0 select gain 1, 2, 4 or 8.
// - Reads and writes at one offset reach different functions.
// - Any write to offset 12 starts a conversion in software trigger mode.
// - Any write to offset 8 clears the interrupt status flag, unless a done arrives in the same cycle in interrupt mode.
module ahrd_top (
  input wire logic core_clk_i, // 10 MHz core clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [ahrd_pkg::ADDR_W-1:0] io_addr_i, // Host I/O address pins
  input wire logic [7:0] io_data_i, // Host data bus, write direction
  input wire logic io_rd_n_i, // Host read strobe, active low
  input wire logic io_wr_n_i, // Host write strobe, active low
  input wire logic [ahrd_pkg::BASE_W-1:0] base_sel_i, // Base address jumpers, A9..A4
  output logic [7:0] io_data_o, // Read data toward host
  output logic io_data_oe_o, // High while driving the data bus
  input wire logic conv_done_i, // Converter end of conversion, one cycle
  input wire logic [15:0] conv_result_i, // Converter result, valid with done
  output logic conv_start_o, // Conversion start pulse
  output ahrd_pkg::ahrd_mux_t mux_o, // Multiplexer control
  output logic [1:0] gain_code_o, // Gain stage code
  output logic [2:0] acq_mode_o, // Acquisition mode
  output logic irq_flag_o, // Interrupt status flag
  output logic [ahrd_pkg::DAC_W-1:0] dac_one_o, // Analog output one
  output logic [ahrd_pkg::DAC_W-1:0] dac_two_o, // Analog output two
  input wire logic [15:0] dig_in_i, // Digital input pins
  output logic [15:0] dig_out_o, // Digital outputs
  input wire logic [7:0] timer_rdata_i, // Timer read data, same clock
  output logic [1:0] timer_sel_o, // Timer port select
  output logic [7:0] timer_wdata_o, // Timer write data
  output logic timer_wr_o, // Timer write pulse
  output logic timer_rd_o // Timer read pulse
);
  import ahrd_pkg::*;

  function automatic ahrd_mux_t decode_mux(input logic [7:0] v);
    ahrd_mux_t m;
    m.low_bank_en = v[BANK_LO_BIT];
    m.high_bank_en = v[BANK_HI_BIT];
    m.differential = v[BANK_LO_BIT] & v[BANK_HI_BIT];
    m.channel_index = v[CHAN_IDX_LSB +: 4];
    return m;
  endfunction

  // Pins cross into the core clock through two flops
  ahrd_host_t host_s1_ff, host_s2_ff;
  logic [BASE_W-1:0] base_s1_ff, base_s2_ff;
  logic [15:0] din_s1_ff, din_s2_ff;
  logic rd_prev_ff, wr_prev_ff;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      host_s1_ff <= '{addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1};
      host_s2_ff <= '{addr: '0, data: '0, rd_n: 1'b1, wr_n: 1'b1};
      base_s1_ff <= '0;
      base_s2_ff <= '0;
      din_s1_ff <= '0;
      din_s2_ff <= '0;
      rd_prev_ff <= 1'b1;
      wr_prev_ff <= 1'b1;
    end else begin
      host_s1_ff <= '{addr: io_addr_i, data: io_data_i, rd_n: io_rd_n_i, wr_n: io_wr_n_i};
      host_s2_ff <= host_s1_ff;
      base_s1_ff <= base_sel_i;
      base_s2_ff <= base_s1_ff;
      din_s1_ff <= dig_in_i;
      din_s2_ff <= din_s1_ff;
      rd_prev_ff <= host_s2_ff.rd_n;
      wr_prev_ff <= host_s2_ff.wr_n;
    end
  end

  logic hit;
  logic [3:0] off;
  logic rd_start, rd_end, wr_end;

  assign hit = (host_s2_ff.addr[ADDR_W-1:OFF_W] == base_s2_ff);
  assign off = host_s2_ff.addr[OFF_W-1:0];
  // Reads act on the strobe's leading edge, writes on its trailing edge
  assign rd_start = rd_prev_ff & ~host_s2_ff.rd_n;
  assign rd_end = ~rd_prev_ff & host_s2_ff.rd_n;
  assign wr_end = ~wr_prev_ff & host_s2_ff.wr_n;

  logic [7:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic [15:0] result_ff, nxt_result;
  logic pending_ff, nxt_pending;
  logic irq_ff, nxt_irq;
  logic start_ff, nxt_start;
  ahrd_mux_t mux_ff, nxt_mux;
  logic [1:0] gain_ff, nxt_gain;
  logic [2:0] mode_ff, nxt_mode;
  logic [7:0] dac1_lo_ff, nxt_dac1_lo, dac2_lo_ff, nxt_dac2_lo;
  logic [DAC_W-1:0] dac1_ff, nxt_dac1, dac2_ff, nxt_dac2;
  logic [15:0] dout_pins_ff, nxt_dout_pins;
  logic [1:0] tsel_ff, nxt_tsel;
  logic [7:0] twdata_ff, nxt_twdata;
  logic twr_ff, nxt_twr, trd_ff, nxt_trd;

  logic rd_hit, wr_hit;
  assign rd_hit = rd_start & hit;
  assign wr_hit = wr_end & hit;

  always_comb begin
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    nxt_result = result_ff;
    nxt_pending = pending_ff;
    nxt_irq = irq_ff;
    nxt_start = 1'b0;
    nxt_mux = mux_ff;
    nxt_gain = gain_ff;
    nxt_mode = mode_ff;
    nxt_dac1_lo = dac1_lo_ff;
    nxt_dac2_lo = dac2_lo_ff;
    nxt_dac1 = dac1_ff;
    nxt_dac2 = dac2_ff;
    nxt_dout_pins = dout_pins_ff;
    nxt_tsel = tsel_ff;
    nxt_twdata = twdata_ff;
    nxt_twr = 1'b0;
    nxt_trd = 1'b0;

    // Result stored as delivered, two's complement, bit order kept
    if (conv_done_i) begin
      nxt_result = conv_result_i;
      nxt_pending = 1'b0;
      if (mode_ff == MODE_IRQ) begin
        nxt_irq = 1'b1;
      end
    end

    if (rd_hit) begin
      nxt_oe = 1'b1;
      case (off)
        OFF_CNT0, OFF_CNT1, OFF_CNT2: begin
          nxt_dout = timer_rdata_i;
          nxt_tsel = off[1:0];
          nxt_trd = 1'b1;
        end
        OFF_RES_LO: begin
          nxt_dout = result_ff[7:0];
          nxt_pending = 1'b1;
        end
        OFF_RES_HI: nxt_dout = result_ff[15:8];
        OFF_DIN_LO: nxt_dout = din_s2_ff[7:0];
        OFF_DIN_HI: nxt_dout = din_s2_ff[15:8];
        OFF_STATUS: begin
          nxt_dout = 8'h00;
          nxt_dout[STAT_PEND_BIT] = pending_ff;
        end
        default: nxt_dout = UNUSED_READ;
      endcase
    end else if (rd_end) begin
      nxt_oe = 1'b0;
    end

    if (wr_hit) begin
      case (off)
        OFF_CNT0, OFF_CNT1, OFF_CNT2, OFF_TCTL: begin
          nxt_tsel = off[1:0];
          nxt_twdata = host_s2_ff.data;
          nxt_twr = 1'b1;
        end
        OFF_RES_LO: nxt_dac1_lo = host_s2_ff.data;
        // High byte write updates the whole output, no half-step
        OFF_RES_HI: nxt_dac1 = {host_s2_ff.data[3:0], dac1_lo_ff};
        OFF_DIN_LO: nxt_dac2_lo = host_s2_ff.data;
        OFF_DIN_HI: nxt_dac2 = {host_s2_ff.data[3:0], dac2_lo_ff};
        OFF_STATUS: begin
          // A done in the same cycle in interrupt mode keeps the flag set
          if (!(conv_done_i && mode_ff == MODE_IRQ)) begin
            nxt_irq = 1'b0;
          end
        end
        OFF_GAIN: nxt_gain = host_s2_ff.data[1:0];
        OFF_CHAN: nxt_mux = decode_mux(host_s2_ff.data);
        OFF_MODE: nxt_mode = host_s2_ff.data[2:0];
        OFF_KICK: begin
          if (mode_ff == MODE_SOFT) begin
            nxt_start = 1'b1;
          end
        end
        OFF_DOUT_LO: nxt_dout_pins[7:0] = host_s2_ff.data;
        OFF_DOUT_HI: nxt_dout_pins[15:8] = host_s2_ff.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dout_ff <= RST_BYTE;
      oe_ff <= 1'b0;
      result_ff <= '0;
      pending_ff <= RST_PENDING;
      irq_ff <= 1'b0;
      start_ff <= 1'b0;
      mux_ff <= '0;
      gain_ff <= RST_GAIN;
      mode_ff <= RST_MODE;
      dac1_lo_ff <= RST_BYTE;
      dac2_lo_ff <= RST_BYTE;
      dac1_ff <= '0;
      dac2_ff <= '0;
      dout_pins_ff <= '0;
      tsel_ff <= '0;
      twdata_ff <= RST_BYTE;
      twr_ff <= 1'b0;
      trd_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
      result_ff <= nxt_result;
      pending_ff <= nxt_pending;
      irq_ff <= nxt_irq;
      start_ff <= nxt_start;
      mux_ff <= nxt_mux;
      gain_ff <= nxt_gain;
      mode_ff <= nxt_mode;
      dac1_lo_ff <= nxt_dac1_lo;
      dac2_lo_ff <= nxt_dac2_lo;
      dac1_ff <= nxt_dac1;
      dac2_ff <= nxt_dac2;
      dout_pins_ff <= nxt_dout_pins;
      tsel_ff <= nxt_tsel;
      twdata_ff <= nxt_twdata;
      twr_ff <= nxt_twr;
      trd_ff <= nxt_trd;
    end
  end

  assign io_data_o = dout_ff;
  assign io_data_oe_o = oe_ff;
  assign conv_start_o = start_ff;
  assign mux_o = mux_ff;
  assign gain_code_o = gain_ff;
  assign acq_mode_o = mode_ff;
  assign irq_flag_o = irq_ff;
  assign dac_one_o = dac1_ff;
  assign dac_two_o = dac2_ff;
  assign dig_out_o = dout_pins_ff;
  assign timer_sel_o = tsel_ff;
  assign timer_wdata_o = twdata_ff;
  assign timer_wr_o = twr_ff;
  assign timer_rd_o = trd_ff;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence rd_at(logic [3:0] o);
    rd_start && hit && off == o;
  endsequence

  sequence wr_at(logic [3:0] o);
    wr_end && hit && off == o;
  endsequence

  outside_quiet_a: assert property (rd_start && !hit && !oe_ff |=> !oe_ff)
    else $error("Read outside block drove the bus");

  low_byte_a: assert property (rd_at(OFF_RES_LO) |=>
    io_data_oe_o && io_data_o == $past(result_ff[7:0]))
    else $error("Low result byte wrong");

  high_byte_a: assert property (rd_at(OFF_RES_HI) |=> io_data_o == $past(result_ff[15:8]))
    else $error("High result byte wrong");

  result_ro_a: assert property (wr_at(OFF_RES_HI) ##0 !conv_done_i |=>
    $stable(result_ff) && dac_one_o[7:0] == $past(dac1_lo_ff))
    else $error("Result port write misrouted");

  // Low byte alone must not move the output, else it steps twice
  dac_hold_a: assert property (wr_at(OFF_RES_LO) |=> $stable(dac_one_o))
    else $error("Analog output moved on low byte");

  status_bit_a: assert property (rd_at(OFF_STATUS) |=>
    io_data_o[STAT_PEND_BIT] == $past(pending_ff) && io_data_o[4:0] == 5'h00)
    else $error("Status pending bit wrong");

  done_clears_a: assert property (conv_done_i && !(rd_hit && off == OFF_RES_LO) |=>
    !pending_ff && result_ff == $past(conv_result_i))
    else $error("Done did not clear pending");

  low_read_sets_a: assert property (rd_at(OFF_RES_LO) |=> pending_ff)
    else $error("Low byte read left pending clear");

  chan_switch_a: assert property (wr_at(OFF_CHAN) |=>
    mux_o.channel_index == $past(host_s2_ff.data[3:0])
    && mux_o.differential == ($past(host_s2_ff.data[5:4]) == 2'h3))
    else $error("Channel write not applied");

  // One property per nonzero bank pattern so a swapped enable shows up by name
  bank_low_a: assert property (wr_at(OFF_CHAN) ##0 host_s2_ff.data[5:4] == 2'h1 |=>
    mux_o.low_bank_en && !mux_o.high_bank_en && !mux_o.differential)
    else $error("Low bank not selected");

  bank_high_a: assert property (wr_at(OFF_CHAN) ##0 host_s2_ff.data[5:4] == 2'h2 |=>
    !mux_o.low_bank_en && mux_o.high_bank_en && !mux_o.differential)
    else $error("High bank not selected");

  diff_mode_a: assert property (wr_at(OFF_CHAN) ##0 host_s2_ff.data[5:4] == 2'h3 |=>
    mux_o.differential && mux_o.low_bank_en && mux_o.high_bank_en)
    else $error("Differential mode not selected");

  gain_load_a: assert property (wr_at(OFF_GAIN) |=>
    gain_code_o == $past(host_s2_ff.data[1:0]))
    else $error("Gain code not applied");

  kick_start_a: assert property (wr_at(OFF_KICK) ##0 mode_ff == MODE_SOFT |=>
    conv_start_o ##1 !conv_start_o)
    else $error("Software trigger missed");

  irq_set_a: assert property (conv_done_i && mode_ff == MODE_IRQ |=> irq_flag_o)
    else $error("Interrupt flag not raised");

  irq_clear_a: assert property (wr_at(OFF_STATUS) ##0 !conv_done_i |=> !irq_flag_o)
    else $error("Interrupt flag not cleared");

  din_read_a: assert property (rd_at(OFF_DIN_LO) |=>
    io_data_o == $past(din_s2_ff[7:0]))
    else $error("Digital input byte wrong");

  timer_read_a: assert property (rd_at(OFF_CNT1) |=>
    timer_rd_o && timer_sel_o == 2'h1 && io_data_o == $past(timer_rdata_i))
    else $error("Timer read not passed on");

  timer_write_a: assert property (wr_at(OFF_TCTL) |=>
    timer_wr_o && timer_sel_o == 2'h3 && timer_wdata_o == $past(host_s2_ff.data)
    ##1 !timer_wr_o)
    else $error("Timer write not passed on");

  unused_read_a: assert property (rd_at(OFF_GAIN) ##0 !conv_done_i |=>
    io_data_o == UNUSED_READ && $stable(pending_ff))
    else $error("Unused read had an effect");

  spare_write_a: assert property (wr_at(OFF_SPARE) |=>
    $stable(dig_out_o) && $stable(mux_o) && $stable(gain_code_o) && $stable(acq_mode_o))
    else $error("Spare write had an effect");

endmodule

`default_nettype wire
